// *** src/tprb_defs.svh ***
// Contract
// - One-cycle read pulse starts the read
// - Busy stays high while settings are fetched
// - Completion drops busy, raises valid
// - Each channel shown in its own slice
// - Three swing bits per channel, ascending
`ifndef TPRB_DEFS_SVH
`define TPRB_DEFS_SVH

// ****************************************
// Encodings and timing
// ****************************************
`define TPRB_DIR_TX_ONLY 2'h2
`define TPRB_SWING_BITS 3
`define TPRB_FETCH_CYCLES 8'h04
`define TPRB_FETCH_W 8

`endif

// *** src/tprb_pkg.sv ***
package tprb_pkg;
  // One-hot states of the read-back sequencer
  typedef enum logic [2:0]
  {
    TPRB_IDLE = 3'h1,
    TPRB_FETCH = 3'h2,
    TPRB_DONE = 3'h4
  } tprb_state_t;
endpackage

// *** src/tprb_readback.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tprb_defs.svh"

module tprb_readback #(
  parameter int CHANNELS = 2,
  parameter logic [`TPRB_FETCH_W-1:0] FETCH_CYCLES = `TPRB_FETCH_CYCLES
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic read,
  input wire logic write,
  input wire logic [1:0] dir_sel,
  input wire logic [`TPRB_SWING_BITS*CHANNELS-1:0] chan_swing,
  output logic busy,
  output logic data_valid,
  output logic [`TPRB_SWING_BITS*CHANNELS-1:0] tx_swing_out
);

  // ****************************************
  // Overview
  // ****************************************
  // Read-back side of the channel settings controller.
  // A one-cycle read pulse taken while idle starts a fetch.
  // Busy stands through the fetch and the capture cycle.
  // Valid rises as busy falls and stands until the next read.
  // Swing slices are captured only for a transmit-only read.
  // Other directions still finish and raise valid, so a
  // requester never waits forever on a wrong selection.
  // Limitation: no abort; a started fetch always runs out.
  // Trade-off: a fixed fetch length keeps the sequencer tiny,
  // at the price of not modelling a slow channel answer.
  // A read that meets a write in the same cycle is refused,
  // since the requester broke its side of the handshake and
  // a half-defined fetch would be worse than none.
  // All inputs come from logic on this same clock, so no
  // synchroniser stages sit in front of them.
  //
  // Cycle walk of one accepted read, edge by edge:
  //   c0: read sampled high while idle, fetch begins
  //   c1..c3: fetch counter runs
  //   c4: counter at its end, capture state entered
  //   c5: swing captured, valid set, back to idle
  // Busy is therefore high for the fetch length plus one.
  //
  // Channel n owns bits [3n+2:3n] of both swing buses,
  // channel zero lowest; capture copies the whole bus, so
  // slice order is kept without any per-channel logic.

  // ****************************************
  // Sequencer
  // ****************************************
  tprb_pkg::tprb_state_t state; // Current state
  tprb_pkg::tprb_state_t next_state; // Next state
  logic [`TPRB_FETCH_W-1:0] count; // Fetch cycle counter
  // Idle flag used only to form start, which feeds the decode and the valid clear
  wire idle = (state == tprb_pkg::TPRB_IDLE);
  // Read and write together is a requester fault; refuse it
  wire clash = read && write;
  // A read is taken only from idle and without a clash
  wire start = read && !clash && idle;
  wire fetch_end = (state == tprb_pkg::TPRB_FETCH) && (count == FETCH_CYCLES - 1'b1);
  // Transmit-only selection decides whether swing is captured
  wire tx_sel = (dir_sel == `TPRB_DIR_TX_ONLY);

  // Next-state decode
  always_comb
  begin
    next_state = state;
    unique case (state)
      tprb_pkg::TPRB_IDLE:
      begin
        if (start)
          next_state = tprb_pkg::TPRB_FETCH;
      end
      tprb_pkg::TPRB_FETCH:
      begin
        if (fetch_end)
          next_state = tprb_pkg::TPRB_DONE;
      end
      tprb_pkg::TPRB_DONE:
      begin
        // Capture cycle lasts exactly one clock
        next_state = tprb_pkg::TPRB_IDLE;
      end
      default:
      begin
        // Illegal one-hot code: fall back to idle
        next_state = tprb_pkg::TPRB_IDLE;
      end
    endcase
  end

  // State and counter
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= tprb_pkg::TPRB_IDLE;
      count <= '0;
    end
    else
    begin
      state <= next_state;
      count <= (state == tprb_pkg::TPRB_FETCH) ? count + 1'b1 : '0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Busy covers fetch and capture so valid and busy-low line up
  assign busy = (state != tprb_pkg::TPRB_IDLE);

  // Valid and captured data; slices follow channel order
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      data_valid <= 1'b0;
      tx_swing_out <= '0;
    end
    else if (start)
      data_valid <= 1'b0;
    else if (state == tprb_pkg::TPRB_DONE)
    begin
      data_valid <= 1'b1;
      if (tx_sel)
        tx_swing_out <= chan_swing;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  busy_after_read_a:
    assert property (@(posedge clock) disable iff (!rstn)
      (read && !busy) |=> busy [*4])
    else $error("busy not held after read");
  valid_at_end_a:
    assert property (@(posedge clock) disable iff (!rstn)
      $fell(busy) |-> data_valid)
    else $error("valid missing at busy fall");
  ignore_busy_a:
    assert property (@(posedge clock) disable iff (!rstn)
      (busy && state == tprb_pkg::TPRB_FETCH) |=> busy)
    else $error("busy dropped mid fetch");
  clear_valid_a:
    assert property (@(posedge clock) disable iff (!rstn)
      (read && !busy) |=> !data_valid)
    else $error("valid not cleared on start");
  done_span_a:
    assert property (@(posedge clock) disable iff (!rstn)
      (read && !busy) |-> ##[6:6] !busy)
    else $error("read length wrong");
  slice_load_a:
    assert property (@(posedge clock) disable iff (!rstn)
      (state == tprb_pkg::TPRB_DONE && tx_sel) |=> tx_swing_out == $past(chan_swing))
    else $error("swing slices not loaded");
  hold_data_a:
    assert property (@(posedge clock) disable iff (!rstn)
      (state != tprb_pkg::TPRB_DONE) |=> $stable(tx_swing_out))
    else $error("swing changed outside capture");
  valid_busy_a:
    assert property (@(posedge clock) disable iff (!rstn)
      data_valid |-> !busy)
    else $error("valid while busy");

  // Valid stands until a new read is taken
  valid_hold_a:
    assert property (@(posedge clock) disable iff (!rstn)
      (data_valid && !read) |=> data_valid)
    else $error("valid dropped without a read");

  // Idle with no read stays idle
  idle_quiet_a:
    assert property (@(posedge clock) disable iff (!rstn)
      (!busy && !read) |=> !busy)
    else $error("busy rose without a read");

  // A read in the capture cycle must not restart a fetch
  refuse_read_a:
    assert property (@(posedge clock) disable iff (!rstn)
      (read && busy && state == tprb_pkg::TPRB_DONE) |=> !busy)
    else $error("read taken while busy");

  // Swing slices move only together with a rising valid
  swing_with_valid_a:
    assert property (@(posedge clock) disable iff (!rstn)
      $changed(tx_swing_out) |-> $rose(data_valid))
    else $error("swing changed without valid");

  // State register always holds exactly one hot bit
  state_onehot_a:
    assert property (@(posedge clock) disable iff (!rstn)
      $onehot(state))
    else $error("state not one hot");

  // Fetch counter never runs past FETCH_CYCLES, reached in the capture cycle
  count_range_a:
    assert property (@(posedge clock) disable iff (!rstn)
      count <= FETCH_CYCLES)
    else $error("fetch counter overran");

  // ****************************************
  // Coverage
  // ****************************************
  // Main scenarios: accepted read, refused read, completion,
  // a read with another direction, a read in the capture cycle
  read_cov: cover property (@(posedge clock) disable iff (!rstn) read && !busy);
  ignored_cov: cover property (@(posedge clock) disable iff (!rstn) read && busy);
  done_cov: cover property (@(posedge clock) disable iff (!rstn) $rose(data_valid));
  skip_cov: cover property (@(posedge clock) disable iff (!rstn) state == tprb_pkg::TPRB_DONE && !tx_sel);
  late_read_cov: cover property (@(posedge clock) disable iff (!rstn) read && state == tprb_pkg::TPRB_DONE);

endmodule // tprb_readback
`default_nettype wire

// *** tb/tprb_readback_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module tprb_readback_bench;
  // ****
  // Stimulus and wiring
  // ****
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic tx_only = 1'b1;
  logic read, write, busy, data_valid;
  logic [1:0] dir_sel;
  logic [5:0] chan_swing = 6'h00;
  logic [5:0] tx_swing_out;
  int err_total = 0;
  int check_count = 0;
  always #25 clock = ~clock;
  tprb_user u_user (.clock(clock), .go(go), .tx_only(tx_only), .read(read), .write(write), .dir_sel(dir_sel));
  tprb_readback u_dut (.clock(clock), .rstn(rstn), .read(read), .write(write), .dir_sel(dir_sel),
    .chan_swing(chan_swing), .busy(busy), .data_valid(data_valid), .tx_swing_out(tx_swing_out));
  // Compare one value
  task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    begin
      check_count++;
      if (g !== e)
      begin
        err_total++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // One read; tw injects a second read while busy
  task automatic xfer(input logic [5:0] s, input bit tw, input bit tx, input logic [5:0] e);
    begin
      @(negedge clock) chan_swing = s;
      tx_only = tx;
      @(posedge clock) go = 1'b1;
      @(posedge clock) go = 1'b0;
      for (int i = 1; i < 8; i++)
      begin
        @(posedge clock) go = tw && i == 4;
        @(negedge clock) chk("busy", 6'(i < 5), {5'h00, busy});
        chk("valid", 6'(i > 4), {5'h00, data_valid});
      end
      chk("swing", e, tx_swing_out);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run;
    begin
      if (err_total == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Main sequence; channel values differ per slice except 6'h3f, the read that is not captured
  initial
  begin
    repeat (20) @(posedge clock);
    @(negedge clock) chk("reset", 6'h00, {busy, data_valid, tx_swing_out[3:0]});
    rstn = 1'b1;
    xfer(6'h11, 1'b0, 1'b1, 6'h11);
    xfer(6'h2e, 1'b1, 1'b1, 6'h2e);
    xfer(6'h3f, 1'b0, 1'b0, 6'h2e);
    xfer(6'h07, 1'b0, 1'b1, 6'h07);
    complete_run();
  end
  // Watchdog against a hang
  initial
  begin
    repeat (400) @(posedge clock);
    err_total++;
    complete_run();
  end
endmodule // tprb_readback_bench
`default_nettype wire

// *** tb/tprb_user.sv ***
`timescale 1ns/10ps
`default_nettype none
// Requesting logic: one read pulse per go
module tprb_user (
  input wire logic clock,
  input wire logic go,
  input wire logic tx_only,
  output logic read,
  output logic write,
  output logic [1:0] dir_sel
);
  // Launch on falling edge, clear of sampling
  initial
  begin
    {read, write, dir_sel} = 4'h2;
    forever @(negedge clock)
    begin
      read = go;
      dir_sel = tx_only ? 2'b10 : 2'b11;
    end
  end
endmodule // tprb_user
`default_nettype wire
